//--- core/tgw_window.sv
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/1ps
`include "tgw_regs.svh"
// Operation
// RL1: modes off, gating, trigger; off cancels window
// RL2: gating polarity bit selects active level
// RL3: gating window follows trigger input level
// RL4: edge select bit; edge starts delay
// RL5: delay expiry opens window for gate time
// RL6: edges ignored during holdoff after window
// RL7: delay 0..65535 ticks of 5 us
// RL8: gate 1..65535 ticks, zero refused
// RL9: holdoff 0..65535 ticks from window end
// RL10: intervals accurate to cycle-exact ticks
// RL11: window routed to one selected channel
// RL12: per-channel time gating indicator
// RL13: zero delay still has latency
// RL14: 16-bit tick counters with terminal count
module tgw_window #(
  parameter int TICK_CYC = `TGW_TICK_CYC
) (
  input  wire logic        i_mclk,
  input  wire logic        i_reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        i_trig,
  input  wire logic [1:0]  i_sensor_ok,
  output logic [1:0]       o_meas_en,
  output logic [1:0]       o_gated_ind
);
  initial begin
    if (TICK_CYC != `TGW_TICK_CYC) $error("tick must be 5 us at 200 MHz");
  end

  // ****************************
  // register bus
  // ****************************
  tgw_pkg::tgw_cfg_t cfg_q;
  logic              wr;
  logic              rd;
  logic              bad_val;
  logic              hit;

  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign hit = (paddr == `TGW_CTRL_OFF) || (paddr == `TGW_DELAY_OFF) || (paddr == `TGW_GATE_OFF) ||
               (paddr == `TGW_HOLD_OFF) || (paddr == `TGW_STATUS_OFF);
  // refuse zero gate, absent sensor, illegal mode
  assign bad_val = ((paddr == `TGW_GATE_OFF) && (pwdata[15:0] == 16'h0000)) ||  // [RL8]
                   ((paddr == `TGW_CTRL_OFF) && (pwdata[1:0] == 2'h3)) ||
                   ((paddr == `TGW_CTRL_OFF) && (pwdata[1:0] != 2'h0) &&
                    !i_sensor_ok[pwdata[`TGW_CTRL_CHAN_BIT]]);  // [RL11]
  assign pslverr = psel && penable && (!hit || (pwrite && bad_val));

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      cfg_q.mode   <= tgw_pkg::TGW_MODE_OFF;
      cfg_q.invert <= 1'b0;
      cfg_q.chan_b <= 1'b0;
      cfg_q.delay  <= `TGW_DELAY_RST;
      cfg_q.gate   <= `TGW_GATE_RST;
      cfg_q.hold   <= `TGW_HOLD_RST;
    end else if (wr && !bad_val) begin
      case (paddr)
        `TGW_CTRL_OFF: begin
          cfg_q.mode   <= tgw_pkg::tgw_mode_t'(pwdata[`TGW_CTRL_MODE_LSB +: 2]);  // [RL1]
          cfg_q.invert <= pwdata[`TGW_CTRL_POL_BIT];  // [RL2] [RL4]
          cfg_q.chan_b <= pwdata[`TGW_CTRL_CHAN_BIT];  // [RL11]
        end
        `TGW_DELAY_OFF: cfg_q.delay <= pwdata[15:0];  // [RL7]
        `TGW_GATE_OFF:  cfg_q.gate  <= pwdata[15:0];  // [RL8]
        `TGW_HOLD_OFF:  cfg_q.hold  <= pwdata[15:0];  // [RL9]
        default: ;
      endcase
    end
  end

  tgw_pkg::tgw_state_t st_q;
  logic                win_q;

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `TGW_CTRL_OFF:   prdata <= {28'h0000000, cfg_q.chan_b, cfg_q.invert, cfg_q.mode};
        `TGW_DELAY_OFF:  prdata <= {16'h0000, cfg_q.delay};
        `TGW_GATE_OFF:   prdata <= {16'h0000, cfg_q.gate};
        `TGW_HOLD_OFF:   prdata <= {16'h0000, cfg_q.hold};
        `TGW_STATUS_OFF: prdata <= {25'h0000000, win_q, i_sensor_ok, st_q};
        default:         prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************
  // trigger sequencer
  // ****************************
  logic trig_q;
  logic edge_hit;
  logic load;
  logic expire;
  logic [15:0] ticks;

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      trig_q <= 1'b0;
    end else begin
      trig_q <= i_trig;
    end
  end

  // invert picks falling edge
  assign edge_hit = cfg_q.invert ? (trig_q && !i_trig) : (!trig_q && i_trig);  // [RL4]

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n || cfg_q.mode != tgw_pkg::TGW_MODE_TRIG) begin
      st_q <= tgw_pkg::TGW_ST_IDLE;
    end else begin
      case (st_q)
        tgw_pkg::TGW_ST_IDLE:  if (edge_hit) st_q <= tgw_pkg::TGW_ST_DELAY;  // [RL4] [RL6]
        tgw_pkg::TGW_ST_DELAY: if (expire) st_q <= tgw_pkg::TGW_ST_GATE;  // [RL5] [RL13]
        tgw_pkg::TGW_ST_GATE:  if (expire) st_q <= tgw_pkg::TGW_ST_HOLD;  // [RL5]
        tgw_pkg::TGW_ST_HOLD:  if (expire) st_q <= tgw_pkg::TGW_ST_IDLE;  // [RL6] [RL9]
        default:               st_q <= tgw_pkg::TGW_ST_IDLE;
      endcase
    end
  end

  // a phase's counter loads on entry; each phase lasts n ticks plus its expiry cycle
  assign load = (st_q == tgw_pkg::TGW_ST_IDLE && edge_hit && cfg_q.mode == tgw_pkg::TGW_MODE_TRIG) ||
                (st_q != tgw_pkg::TGW_ST_IDLE && st_q != tgw_pkg::TGW_ST_HOLD && expire);
  assign ticks = (st_q == tgw_pkg::TGW_ST_IDLE)  ? cfg_q.delay :
                 (st_q == tgw_pkg::TGW_ST_DELAY) ? cfg_q.gate : cfg_q.hold;  // [RL8] [RL10]

  tgw_tick_timer #(
    .TICK_CYC (TICK_CYC)
  ) u_timer (
    .i_mclk    (i_mclk),
    .i_reset_n (i_reset_n),
    .i_load    (load),
    .i_ticks   (ticks),
    .o_expire  (expire)
  );

  // ****************************
  // window outputs
  // ****************************
  logic win_d;

  always_comb begin
    case (cfg_q.mode)
      tgw_pkg::TGW_MODE_GATE: win_d = i_trig ^ cfg_q.invert;  // [RL2] [RL3]
      tgw_pkg::TGW_MODE_TRIG: win_d = (st_q == tgw_pkg::TGW_ST_GATE);  // [RL5] [RL10]
      default:                win_d = 1'b0;  // [RL1]
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      win_q <= 1'b0;
    end else begin
      win_q <= win_d;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      o_meas_en   <= 2'h0;
      o_gated_ind <= 2'h0;
    end else begin
      // off means ungated: enable both channels
      o_meas_en   <= (cfg_q.mode == tgw_pkg::TGW_MODE_OFF) ? 2'h3 :
                     (cfg_q.chan_b ? {win_d, 1'b1} : {1'b1, win_d});  // [RL1] [RL11]
      o_gated_ind <= (cfg_q.mode == tgw_pkg::TGW_MODE_OFF) ? 2'h0 :
                     (cfg_q.chan_b ? 2'h2 : 2'h1);  // [RL12]
    end
  end

  // ****************************
  // phase bookkeeping
  // ****************************
  // cycles a phase of n ticks runs before its expiry cycle
  function automatic logic [31:0] tgw_span(input logic [15:0] n);
    return 32'(n) * 32'(TICK_CYC);
  endfunction

  logic [31:0] phase_len_q;
  logic [15:0] phase_set_q;

  // restarts on every load, so it times the phase just entered
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n || load) begin
      phase_len_q <= 32'h0000_0000;
    end else begin
      phase_len_q <= phase_len_q + 32'h0000_0001;
    end
  end

  // ticks the running phase was loaded with; later writes do not move it
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      phase_set_q <= 16'h0000;
    end else if (load) begin
      phase_set_q <= ticks;
    end
  end

  // ****************************
  // checks
  // ****************************
  sequence trig_start_s;
    edge_hit && st_q == tgw_pkg::TGW_ST_IDLE && cfg_q.mode == tgw_pkg::TGW_MODE_TRIG;
  endsequence

  sequence delay_done_s;
    st_q == tgw_pkg::TGW_ST_DELAY && expire && cfg_q.mode == tgw_pkg::TGW_MODE_TRIG;
  endsequence

  sequence gate_done_s;
    st_q == tgw_pkg::TGW_ST_GATE && expire && cfg_q.mode == tgw_pkg::TGW_MODE_TRIG;
  endsequence

  sequence hold_done_s;
    st_q == tgw_pkg::TGW_ST_HOLD && expire && cfg_q.mode == tgw_pkg::TGW_MODE_TRIG;
  endsequence

  off_no_gate_a : assert property (@(posedge i_mclk) disable iff (!i_reset_n)  // [RL1]
    cfg_q.mode == tgw_pkg::TGW_MODE_OFF |=> o_gated_ind == 2'h0)
    else $error("indicator set while off");
  gate_follow_a : assert property (@(posedge i_mclk) disable iff (!i_reset_n)  // [RL3]
    cfg_q.mode == tgw_pkg::TGW_MODE_GATE && $stable(cfg_q.mode) |=> win_q == ($past(i_trig) ^ $past(cfg_q.invert)))
    else $error("gating window does not follow input");
  gate_pol_a : assert property (@(posedge i_mclk) disable iff (!i_reset_n)  // [RL2]
    cfg_q.mode == tgw_pkg::TGW_MODE_GATE && !cfg_q.invert && !i_trig |=> !win_q)
    else $error("window open on inactive level");
  edge_start_a : assert property (@(posedge i_mclk) disable iff (!i_reset_n)  // [RL4]
    trig_start_s |=> st_q == tgw_pkg::TGW_ST_DELAY || cfg_q.mode != tgw_pkg::TGW_MODE_TRIG)
    else $error("edge did not start delay");
  zero_lat_a : assert property (@(posedge i_mclk) disable iff (!i_reset_n)  // [RL13]
    trig_start_s |=> !win_d)
    else $error("window opened with no latency");
  hold_ignore_a : assert property (@(posedge i_mclk) disable iff (!i_reset_n)  // [RL6]
    st_q == tgw_pkg::TGW_ST_HOLD && !expire && cfg_q.mode == tgw_pkg::TGW_MODE_TRIG
      |=> st_q != tgw_pkg::TGW_ST_DELAY)
    else $error("edge accepted during holdoff");
  gate_order_a : assert property (@(posedge i_mclk) disable iff (!i_reset_n)  // [RL5]
    st_q == tgw_pkg::TGW_ST_GATE |-> $past(st_q) == tgw_pkg::TGW_ST_GATE || $past(st_q) == tgw_pkg::TGW_ST_DELAY)
    else $error("gate entered out of order");
  gate_nonzero_a : assert property (@(posedge i_mclk) disable iff (!i_reset_n)  // [RL8]
    cfg_q.gate != 16'h0000)
    else $error("zero gate time stored");
  chan_ind_a : assert property (@(posedge i_mclk) disable iff (!i_reset_n)  // [RL12]
    o_gated_ind != 2'h3)
    else $error("both channels gated");

  // phase lengths, taken from the ticks each phase was loaded with
  delay_len_a : assert property (@(posedge i_mclk) disable iff (!i_reset_n)  // [RL7] [RL13]
    delay_done_s |-> phase_len_q == tgw_span(phase_set_q))
    else $error("trigger delay length wrong");

  gate_len_a : assert property (@(posedge i_mclk) disable iff (!i_reset_n)  // [RL5] [RL10]
    gate_done_s |-> phase_len_q == tgw_span(phase_set_q))
    else $error("gate window length wrong");

  hold_len_a : assert property (@(posedge i_mclk) disable iff (!i_reset_n)  // [RL9] [RL10]
    hold_done_s |-> phase_len_q == tgw_span(phase_set_q))
    else $error("holdoff length wrong");

  phase_bound_a : assert property (@(posedge i_mclk) disable iff (!i_reset_n)  // [RL14]
    st_q != tgw_pkg::TGW_ST_IDLE && cfg_q.mode == tgw_pkg::TGW_MODE_TRIG |-> phase_len_q <= tgw_span(phase_set_q))
    else $error("phase overran its count");

  // sequence order
  delay_to_gate_a : assert property (@(posedge i_mclk) disable iff (!i_reset_n)  // [RL5]
    delay_done_s |=> st_q == tgw_pkg::TGW_ST_GATE)
    else $error("delay expiry did not open window");

  gate_to_hold_a : assert property (@(posedge i_mclk) disable iff (!i_reset_n)  // [RL6]
    gate_done_s |=> st_q == tgw_pkg::TGW_ST_HOLD)
    else $error("window close did not start holdoff");

  hold_exit_a : assert property (@(posedge i_mclk) disable iff (!i_reset_n)  // [RL6]
    hold_done_s |=> st_q == tgw_pkg::TGW_ST_IDLE)
    else $error("holdoff expiry did not rearm");

  idle_wait_a : assert property (@(posedge i_mclk) disable iff (!i_reset_n)  // [RL4]
    cfg_q.mode == tgw_pkg::TGW_MODE_TRIG && st_q == tgw_pkg::TGW_ST_IDLE && !edge_hit |=> st_q == tgw_pkg::TGW_ST_IDLE)
    else $error("sequence started without an edge");

  rise_edge_a : assert property (@(posedge i_mclk) disable iff (!i_reset_n)  // [RL4]
    cfg_q.mode == tgw_pkg::TGW_MODE_TRIG && st_q == tgw_pkg::TGW_ST_IDLE && !cfg_q.invert && !trig_q && i_trig
      |=> st_q == tgw_pkg::TGW_ST_DELAY)
    else $error("rising edge missed");

  fall_edge_a : assert property (@(posedge i_mclk) disable iff (!i_reset_n)  // [RL4]
    cfg_q.mode == tgw_pkg::TGW_MODE_TRIG && st_q == tgw_pkg::TGW_ST_IDLE && cfg_q.invert && trig_q && !i_trig
      |=> st_q == tgw_pkg::TGW_ST_DELAY)
    else $error("falling edge missed");

  trig_win_a : assert property (@(posedge i_mclk) disable iff (!i_reset_n)  // [RL5]
    cfg_q.mode == tgw_pkg::TGW_MODE_TRIG |=> win_q == ($past(st_q) == tgw_pkg::TGW_ST_GATE))
    else $error("window not tied to gate phase");

  // modes and gating level
  off_idle_a : assert property (@(posedge i_mclk) disable iff (!i_reset_n)  // [RL1]
    cfg_q.mode != tgw_pkg::TGW_MODE_TRIG |=> st_q == tgw_pkg::TGW_ST_IDLE)
    else $error("sequencer running outside trigger mode");

  off_ungated_a : assert property (@(posedge i_mclk) disable iff (!i_reset_n)  // [RL1]
    cfg_q.mode == tgw_pkg::TGW_MODE_OFF |=> o_meas_en == 2'h3)
    else $error("measurement gated while off");

  gate_hi_a : assert property (@(posedge i_mclk) disable iff (!i_reset_n)  // [RL2]
    cfg_q.mode == tgw_pkg::TGW_MODE_GATE && !cfg_q.invert && i_trig |=> win_q)
    else $error("window shut on active high level");

  gate_lo_a : assert property (@(posedge i_mclk) disable iff (!i_reset_n)  // [RL2]
    cfg_q.mode == tgw_pkg::TGW_MODE_GATE && cfg_q.invert && i_trig |=> !win_q)
    else $error("window open on inactive high level");

  // channel routing and indicator
  win_route_a : assert property (@(posedge i_mclk) disable iff (!i_reset_n)  // [RL3] [RL11]
    cfg_q.mode != tgw_pkg::TGW_MODE_OFF && !cfg_q.chan_b |=> win_q == o_meas_en[0])
    else $error("window not routed to channel a");

  chan_a_sel_a : assert property (@(posedge i_mclk) disable iff (!i_reset_n)  // [RL11] [RL12]
    cfg_q.mode != tgw_pkg::TGW_MODE_OFF && !cfg_q.chan_b |=> o_meas_en[1] && o_gated_ind == 2'h1)
    else $error("channel a selection wrong");

  chan_b_sel_a : assert property (@(posedge i_mclk) disable iff (!i_reset_n)  // [RL11] [RL12]
    cfg_q.mode != tgw_pkg::TGW_MODE_OFF && cfg_q.chan_b |=> o_meas_en[0] && o_gated_ind == 2'h2)
    else $error("channel b selection wrong");

  // refused writes
  gate_zero_err_a : assert property (@(posedge i_mclk) disable iff (!i_reset_n)  // [RL8]
    psel && penable && pwrite && paddr == `TGW_GATE_OFF && pwdata[15:0] == 16'h0000 |-> pslverr)
    else $error("zero gate write not refused");

  mode_bad_err_a : assert property (@(posedge i_mclk) disable iff (!i_reset_n)  // [RL1]
    psel && penable && pwrite && paddr == `TGW_CTRL_OFF && pwdata[1:0] == 2'h3 |-> pslverr)
    else $error("illegal mode write not refused");

  sensor_err_a : assert property (@(posedge i_mclk) disable iff (!i_reset_n)  // [RL11]
    psel && penable && pwrite && paddr == `TGW_CTRL_OFF && pwdata[1:0] != 2'h0 &&
      !i_sensor_ok[pwdata[`TGW_CTRL_CHAN_BIT]] |-> pslverr)
    else $error("absent sensor selection not refused");

  refused_keep_a : assert property (@(posedge i_mclk) disable iff (!i_reset_n)  // [RL8] [RL11]
    psel && penable && pwrite && pslverr |=> $stable(cfg_q))
    else $error("refused write changed settings");
endmodule // tgw_window

//--- core/tgw_regs.svh
`ifndef TGW_REGS_SVH
`define TGW_REGS_SVH
// register byte offsets
`define TGW_CTRL_OFF      12'h000
`define TGW_DELAY_OFF     12'h004
`define TGW_GATE_OFF      12'h008
`define TGW_HOLD_OFF      12'h00c
`define TGW_STATUS_OFF    12'h010
// control field positions
`define TGW_CTRL_MODE_LSB 0
`define TGW_CTRL_POL_BIT  2
`define TGW_CTRL_CHAN_BIT 3
// reset values
`define TGW_CTRL_RST      32'h0000_0000
`define TGW_DELAY_RST     16'h0000
`define TGW_GATE_RST      16'h0001
`define TGW_HOLD_RST      16'h0000
// timing
`define TGW_TICK_NS       5000
`define TGW_CLK_NS        5
`define TGW_TICK_CYC      (`TGW_TICK_NS / `TGW_CLK_NS)
`endif

//--- core/tgw_pkg.sv
package tgw_pkg;
  typedef enum logic [1:0] {
    TGW_MODE_OFF  = 2'h0,
    TGW_MODE_GATE = 2'h1,
    TGW_MODE_TRIG = 2'h2
  } tgw_mode_t;

  typedef enum logic [3:0] {
    TGW_ST_IDLE  = 4'h1,
    TGW_ST_DELAY = 4'h2,
    TGW_ST_GATE  = 4'h4,
    TGW_ST_HOLD  = 4'h8
  } tgw_state_t;

  typedef struct packed {
    tgw_mode_t   mode;
    logic        invert;
    logic        chan_b;
    logic [15:0] delay;
    logic [15:0] gate;
    logic [15:0] hold;
  } tgw_cfg_t;
endpackage

//--- core/tgw_tick_timer.sv
`timescale 1ns/1ps
module tgw_tick_timer #(
  parameter int TICK_CYC = 1000
) (
  input  wire logic        i_mclk,
  input  wire logic        i_reset_n,
  input  wire logic        i_load,
  input  wire logic [15:0] i_ticks,
  output logic             o_expire
);
  initial begin
    if (TICK_CYC < 2) $error("tick must span two cycles");
  end

  logic [$clog2(TICK_CYC)-1:0] pre_q;
  logic [15:0]                 cnt_q;
  logic                        run_q;
  logic                        tick;

  assign tick = (pre_q == ($clog2(TICK_CYC))'(TICK_CYC - 1));

  // one prescaler, restarted on every load, keeps each interval exact to one cycle
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n || i_load || tick) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      cnt_q <= 16'h0000;
      run_q <= 1'b0;
    end else if (i_load) begin
      cnt_q <= i_ticks;  // [RL14]
      run_q <= 1'b1;
    end else if (run_q && (cnt_q == 16'h0000)) begin
      run_q <= 1'b0;
    end else if (run_q && tick) begin
      cnt_q <= cnt_q - 16'h0001;
    end
  end

  // terminal count; zero ticks still gives one cycle
  assign o_expire = run_q && (cnt_q == 16'h0000);  // [RL14]
endmodule // tgw_tick_timer

//--- verif/tgw_trig_src.sv
`timescale 1ns/1ps
// ****************************************
// external ttl trigger source
// ****************************************
module tgw_trig_src (
  input  wire logic i_mclk,
  output logic      o_trig
);
  // a ttl source holds its level; it only moves just after an edge
  initial o_trig = 1'b0;
  task automatic drive(input logic lvl);
    @(posedge i_mclk);
    o_trig <= lvl;
  endtask
endmodule // tgw_trig_src

//--- verif/tb.sv
`timescale 1ns/1ps
`include "tgw_regs.svh"
// ****************************************
// time gating window bench
// ****************************************
module tb;
  logic        i_mclk      = 1'b0;
  logic        i_reset_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [1:0]  i_sensor_ok;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        er;
  logic        i_trig;
  logic [1:0]  o_meas_en;
  logic [1:0]  o_gated_ind;
  int          n_fail      = 0;
  int          n_tests     = 0;
  int          cyc         = 0;
  int          lat;
  int          wid;
  logic [43:0] bad [4]     = '{{`TGW_GATE_OFF, 32'h0}, {`TGW_CTRL_OFF, 32'h3},
                               {12'h014, 32'h1}, {`TGW_CTRL_OFF, 32'h9}};

  always #2.5 i_mclk = ~i_mclk;

  tgw_window u_tgw_window (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .i_trig(i_trig), .i_sensor_ok(i_sensor_ok), .o_meas_en(o_meas_en), .o_gated_ind(o_gated_ind));
  tgw_trig_src u_tgw_trig_src (.i_mclk(i_mclk), .o_trig(i_trig));

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // whole run is about 12k cycles
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      complete_run;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge i_mclk);
    penable <= 1'b1;
    // this wait ends once pready is seen high, after one cycle since pready is tied high
    do begin
      @(posedge i_mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // cycles until the channel window opens, then how long it stays open
  task automatic win(input int ch, output int l, output int w);
    l = 0;
    w = 0;
    while (o_meas_en[ch] !== 1'b1 && l < 5000) begin
      @(posedge i_mclk);
      l++;
    end
    while (o_meas_en[ch] === 1'b1 && w < 20000) begin
      @(posedge i_mclk);
      w++;
    end
  endtask

  initial begin
    i_reset_n   <= 1'b0;
    psel        <= 1'b0;
    penable     <= 1'b0;
    pwrite      <= 1'b0;
    paddr       <= 12'h000;
    pwdata      <= 32'h0000_0000;
    i_sensor_ok <= 2'h1;
    repeat (3) @(posedge i_mclk);
    chk(o_meas_en, 32'h0);
    i_reset_n <= 1'b1;
    repeat (2) @(posedge i_mclk);
    chk(o_meas_en, 32'h3);
    apb(1'b0, `TGW_CTRL_OFF, 32'h0);
    chk(rd, `TGW_CTRL_RST);
    apb(1'b0, `TGW_GATE_OFF, 32'h0);
    chk(rd[15:0], `TGW_GATE_RST);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, bad[i][43:32], bad[i][31:0]);
      chk(er, 32'h1);
    end
    apb(1'b0, `TGW_GATE_OFF, 32'h0);
    chk(rd[15:0], 32'h1);
    apb(1'b0, `TGW_CTRL_OFF, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, `TGW_CTRL_OFF, 32'h1);
    u_tgw_trig_src.drive(1'b1);
    repeat (2) @(posedge i_mclk);
    chk({o_gated_ind, o_meas_en}, 32'h7);
    apb(1'b1, `TGW_CTRL_OFF, 32'h5);
    // let the inverted level close the window before timing a pulse
    repeat (2) @(posedge i_mclk);
    fork
      win(0, lat, wid);
      begin
        u_tgw_trig_src.drive(1'b0);
        repeat (19) @(posedge i_mclk);
        u_tgw_trig_src.drive(1'b1);
      end
    join
    chk(wid, 32'h14);
    i_sensor_ok <= 2'h3;
    apb(1'b1, `TGW_DELAY_OFF, 32'h0);
    apb(1'b1, `TGW_GATE_OFF, 32'h1);
    apb(1'b1, `TGW_HOLD_OFF, 32'h1);
    apb(1'b1, `TGW_CTRL_OFF, 32'ha);
    u_tgw_trig_src.drive(1'b0);
    repeat (3) @(posedge i_mclk);
    fork
      win(1, lat, wid);
      u_tgw_trig_src.drive(1'b1);
    join
    chk(lat >= 1 && lat <= 8, 32'h1);
    chk(wid, 32'h3e9);
    chk(o_gated_ind, 32'h2);
    // an edge well inside the holdoff must not restart the sequence
    u_tgw_trig_src.drive(1'b0);
    repeat (300) @(posedge i_mclk);
    fork
      win(1, lat, wid);
      u_tgw_trig_src.drive(1'b1);
    join
    chk(wid, 32'h0);
    u_tgw_trig_src.drive(1'b0);
    fork
      win(1, lat, wid);
      u_tgw_trig_src.drive(1'b1);
    join
    chk(wid, 32'h3e9);
    apb(1'b1, `TGW_DELAY_OFF, 32'h2);
    apb(1'b1, `TGW_HOLD_OFF, 32'h0);
    apb(1'b1, `TGW_CTRL_OFF, 32'h6);
    repeat (1100) @(posedge i_mclk);
    fork
      win(0, lat, wid);
      u_tgw_trig_src.drive(1'b0);
      begin
        repeat (100) @(posedge i_mclk);
        apb(1'b0, `TGW_STATUS_OFF, 32'h0);
        chk(rd[3:0], 32'h2);
      end
    join
    chk(lat >= 'h7d1 && lat <= 'h7d8, 32'h1);
    chk(wid, 32'h3e9);
    apb(1'b1, `TGW_CTRL_OFF, 32'h0);
    repeat (2) @(posedge i_mclk);
    chk({o_gated_ind, o_meas_en}, 32'h3);
    complete_run;
  end
endmodule // tb
